// File: mfac_pkg.sv
// Package with constants and types of the motor fault acknowledge controller.
package mfac_pkg;
	// Clock and timebase.
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_TICK_NS = 1000000;
	// Times in milliseconds.
	localparam int T_PRESS_ACK_MS = 2000;
	localparam int T_PARAM_MS = 6000;
	localparam int T_SHOW_MS = 3000;
	localparam int T_BLANK_MS = 300;
	localparam int T_BLANK_PERIOD_MS = 2000;
	localparam int T_ASYM_SLOW_MS = 120000;
	localparam int T_ASYM_FAST_MS = 2000;
	localparam int T_REMOTE_MS = 2000;
	localparam int T_BLOCK_MS = 2000;
	localparam int T_COOL_MS = 1200000;
	localparam int T_OVL_MS = 10000;
	localparam int T_LAMPTEST_MS = 1000;
	localparam int T_DEBOUNCE_MS = 20;
	localparam int T_FLASH_MS = 500;
	// Currents in milliamperes.
	localparam int RATED_BASE_MA = 75;
	localparam int RATED_STEP_MA = 35;
	localparam int BLOCK_ARM_MA = 45000;
	localparam int I_SAT_MA = 65535;
	// Register offsets.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_STEP = 12'h008;
	// Field positions.
	localparam int CTRL_ACK_BIT = 0;
	localparam int CTRL_REM_EN_BIT = 1;
	// Reset values.
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [3:0] STEP_RST = 4'h0;
	// External fault latch bit positions.
	localparam int EXT_PIN = 0;
	localparam int EXT_ASYM = 1;
	localparam int EXT_BLOCK = 2;
	localparam int EXT_OVL = 3;
	localparam int EXT_REMOTE = 4;
	localparam int EXT_N = 5;
	// Lamp set, code order power, fault, ccw, cw.
	typedef struct packed {
		logic power;
		logic fault;
		logic ccw;
		logic cw;
	} mfac_lamps_t;
	typedef enum logic [2:0] {
		ST_LAMPTEST, ST_RUN, ST_PARAM, ST_SHOW
	} mfac_state_t;
endpackage

// File: mfac_plant.sv
// Far-side model: operator buttons and motor phase currents.
module mfac_plant (
	// Clock.
	input wire logic pclk,
	// Power path from the controller.
	input wire logic motor_en,
	// Pins toward the controller.
	output logic btn_front,
	output logic remote_ack,
	output logic [15:0] i_l1,
	output logic [15:0] i_l3
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS = 4;
	logic [15:0] set_l1 = 16'h0;
	logic [15:0] set_l3 = 16'h0;
	initial begin
		btn_front = 1'b0;
		remote_ack = 1'b0;
		i_l1 = 16'h0;
		i_l3 = 16'h0;
	end
	// Phase current collapses while the power path is open.
	always @(posedge pclk) begin
		i_l1 <= motor_en ? set_l1 : 16'h0;
		i_l3 <= motor_en ? set_l3 : 16'h0;
	end
	// Front button held for the given number of milliseconds.
	task automatic press(input int ms);
		btn_front <= 1'b1;
		repeat (ms * MS) @(posedge pclk);
		btn_front <= 1'b0;
		repeat (8 * MS) @(posedge pclk);
	endtask
	// Remote contact closed for the given number of milliseconds.
	task automatic remote(input int ms);
		remote_ack <= 1'b1;
		repeat (ms * MS) @(posedge pclk);
		remote_ack <= 1'b0;
		repeat (8 * MS) @(posedge pclk);
	endtask
endmodule // mfac_plant

// File: mfac_top.sv
// Motor fault acknowledge controller with APB register access.
// How it works
// - Any latched fault switches the motor power path off.
// - Fault lamp flashes for external errors and is steady for internal ones.
// - Internal errors latch permanently; no acknowledgement clears them.
// - External errors clear on acknowledgement once their cause is gone.
// - A message flashes the power lamp while no fault is latched, keeps power on, needs no acknowledgement.
// - Phase deviation of at least one third trips the motor once it has lasted over two minutes.
// - Phase deviation of at least two thirds trips within two seconds.
// - Front button released under two seconds acknowledges external errors.
// - Front button held over two seconds gives no acknowledgement.
// - Holding over six seconds with no fault latched enters parameterisation; all lamps blank on entry.
// - A rising edge on the remote input acknowledges.
// - Remote input still high two seconds after rising raises an error.
// - With auto strap set, overload trip clears after twenty minutes cooldown.
// - Check-back relay is energised while an error or message is active.
// - Parameterisation quantises the potentiometer into sixteen current steps.
// - Lamps show the step as code power, fault, ccw, cw.
// - Another button press in parameterisation commits the step to storage.
// - Press of two to six seconds shows stored step three seconds when idle.
// - Parameterisation blanks all lamps 0.3 s every two seconds.
// - Blockage monitoring is armed once motor current reaches 45 A.
// - After reset all four lamps light together as a lamp test.
// - Current saturated for over two seconds while armed flags a blockage.
module mfac_top #(
	parameter int CW = 16,
	parameter int TICK_CYC = mfac_pkg::T_TICK_NS / mfac_pkg::CLK_PERIOD_NS,
	parameter logic [23:0] T_PRESS = 24'(mfac_pkg::T_PRESS_ACK_MS),
	parameter logic [23:0] T_PARAM = 24'(mfac_pkg::T_PARAM_MS),
	parameter logic [23:0] T_SHOW = 24'(mfac_pkg::T_SHOW_MS),
	parameter logic [23:0] T_BLANK = 24'(mfac_pkg::T_BLANK_MS),
	parameter logic [23:0] T_BLANK_PER = 24'(mfac_pkg::T_BLANK_PERIOD_MS),
	parameter logic [23:0] T_ASYM_SLOW = 24'(mfac_pkg::T_ASYM_SLOW_MS),
	parameter logic [23:0] T_ASYM_FAST = 24'(mfac_pkg::T_ASYM_FAST_MS),
	parameter logic [23:0] T_REMOTE = 24'(mfac_pkg::T_REMOTE_MS),
	parameter logic [23:0] T_BLOCK = 24'(mfac_pkg::T_BLOCK_MS),
	parameter logic [23:0] T_COOL = 24'(mfac_pkg::T_COOL_MS),
	parameter logic [23:0] T_OVL = 24'(mfac_pkg::T_OVL_MS),
	parameter logic [23:0] T_LAMPTEST = 24'(mfac_pkg::T_LAMPTEST_MS),
	parameter logic [23:0] T_DEBOUNCE = 24'(mfac_pkg::T_DEBOUNCE_MS),
	parameter logic [23:0] T_FLASH = 24'(mfac_pkg::T_FLASH_MS)
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from outside the clock domain.
	input wire logic btn_front,
	input wire logic remote_ack,
	input wire logic auto_strap,
	input wire logic dir_cw,
	input wire logic dir_ccw,
	input wire logic ext_fault,
	// Same-clock inputs from measurement and self test.
	input wire logic [CW-1:0] i_l1,
	input wire logic [CW-1:0] i_l3,
	input wire logic [7:0] pot_pos,
	input wire logic int_fault,
	input wire logic msg_cond,
	// Outputs.
	output logic motor_en,
	output logic check_relay,
	output mfac_pkg::mfac_lamps_t lamps,
	output logic nv_we,
	output logic [3:0] nv_data
);
	localparam int NS = 6;
	logic [NS-1:0] sync1, sync2;
	logic [15:0] tick_cnt;
	logic tick;
	logic btn_db, rem_db, btn_prev, rem_prev;
	logic [23:0] btn_deb_ms, rem_deb_ms;
	logic [23:0] press_ms, rem_ms, lt_ms, param_ms, show_ms, flash_ms;
	logic [23:0] slow_ms, fast_ms, blk_ms, ovl_ms, cool_ms;
	logic blink, param_armed, blk_armed, int_lat;
	logic [mfac_pkg::EXT_N-1:0] ext_lat, ext_set, ext_live, ext_clr;
	logic [1:0] ctrl;
	logic sw_ack;
	logic [3:0] step_stored;
	mfac_pkg::mfac_state_t st;
	mfac_pkg::mfac_lamps_t next_lamps;
	logic btn_rel, rem_rise, ack_evt, fault_any, drv, drive_ccw;
	logic [CW-1:0] imax, imin, iref;
	logic asym33, asym67, sat, ovl_now;

	function automatic logic [CW-1:0] rated_of(input logic [3:0] s);
		rated_of = CW'(mfac_pkg::RATED_BASE_MA + mfac_pkg::RATED_STEP_MA * s);
	endfunction

	function automatic logic ratio_ge(input logic [CW-1:0] d,
		input logic [CW-1:0] r, input logic [1:0] num);
		ratio_ge = ({2'h0, d} * 3) >= ({2'h0, r} * num);
	endfunction

	function automatic logic [23:0] inc_sat(input logic [23:0] v);
		inc_sat = (v == 24'hFFFFFF) ? v : v + 24'h000001;
	endfunction

	// Two-flop synchronisers for all pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {ext_fault, dir_ccw, dir_cw, auto_strap, remote_ack,
				btn_front};
			sync2 <= sync1;
		end
	end

	// Millisecond tick.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 16'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 16'(TICK_CYC - 1)) ? 16'h0000 :
				tick_cnt + 16'h0001;
		end
	end

	// Debounce of front button and remote acknowledge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_db <= 1'b0;
			rem_db <= 1'b0;
			btn_deb_ms <= 24'h000000;
			rem_deb_ms <= 24'h000000;
			btn_prev <= 1'b0;
			rem_prev <= 1'b0;
		end else begin
			btn_prev <= btn_db;
			rem_prev <= rem_db;
			if (sync2[0] == btn_db)
				btn_deb_ms <= 24'h000000;
			else if (tick && btn_deb_ms == T_DEBOUNCE)
				btn_db <= sync2[0];
			else if (tick)
				btn_deb_ms <= btn_deb_ms + 24'h000001;
			if (sync2[1] == rem_db)
				rem_deb_ms <= 24'h000000;
			else if (tick && rem_deb_ms == T_DEBOUNCE)
				rem_db <= sync2[1];
			else if (tick)
				rem_deb_ms <= rem_deb_ms + 24'h000001;
		end
	end

	assign btn_rel = btn_prev && !btn_db;
	assign rem_rise = !rem_prev && rem_db && ctrl[mfac_pkg::CTRL_REM_EN_BIT];
	assign drv = sync2[3] || sync2[4];
	assign drive_ccw = sync2[4];
	assign fault_any = int_lat || (|ext_lat);
	assign imax = (i_l1 > i_l3) ? i_l1 : i_l3;
	assign imin = (i_l1 > i_l3) ? i_l3 : i_l1;
	assign iref = (imax > rated_of(step_stored)) ? imax :
		rated_of(step_stored);
	assign asym33 = drv && ratio_ge(imax - imin, iref, 2'h1);
	assign asym67 = drv && ratio_ge(imax - imin, iref, 2'h2);
	assign sat = imax >= CW'(mfac_pkg::I_SAT_MA);
	assign ovl_now = drv && imax > rated_of(step_stored);
	assign ack_evt = (btn_rel && press_ms < T_PRESS && st == mfac_pkg::ST_RUN)
		|| rem_rise || sw_ack;

	// Press duration, remote high time and flash timebase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			press_ms <= 24'h000000;
			rem_ms <= 24'h000000;
			flash_ms <= 24'h000000;
			blink <= 1'b0;
		end else begin
			if (!btn_db && !btn_prev)
				press_ms <= 24'h000000;
			else if (tick && btn_db)
				press_ms <= inc_sat(press_ms);
			if (!rem_db)
				rem_ms <= 24'h000000;
			else if (tick)
				rem_ms <= inc_sat(rem_ms);
			if (tick && flash_ms >= T_FLASH - 24'h000001) begin
				flash_ms <= 24'h000000;
				blink <= !blink;
			end else if (tick)
				flash_ms <= flash_ms + 24'h000001;
		end
	end

	// Supervision timers for asymmetry, blockage and overload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_ms <= 24'h000000;
			fast_ms <= 24'h000000;
			blk_ms <= 24'h000000;
			ovl_ms <= 24'h000000;
			cool_ms <= 24'h000000;
			blk_armed <= 1'b0;
		end else begin
			slow_ms <= !asym33 ? 24'h000000 : tick ? inc_sat(slow_ms) :
				slow_ms;
			fast_ms <= !asym67 ? 24'h000000 : tick ? inc_sat(fast_ms) :
				fast_ms;
			if (!drv)
				blk_armed <= 1'b0;
			else if (imax >= CW'(mfac_pkg::BLOCK_ARM_MA))
				blk_armed <= 1'b1;
			blk_ms <= !(sat && blk_armed) ? 24'h000000 :
				tick ? inc_sat(blk_ms) : blk_ms;
			ovl_ms <= !ovl_now ? 24'h000000 : tick ? inc_sat(ovl_ms) : ovl_ms;
			cool_ms <= !ext_lat[mfac_pkg::EXT_OVL] ? 24'h000000 :
				tick ? inc_sat(cool_ms) : cool_ms;
		end
	end

	// Fault sources and their live causes.
	always_comb begin
		ext_set = '0;
		ext_live = '0;
		ext_set[mfac_pkg::EXT_PIN] = sync2[5];
		ext_live[mfac_pkg::EXT_PIN] = sync2[5];
		ext_set[mfac_pkg::EXT_ASYM] = (slow_ms > T_ASYM_SLOW) ||
			(fast_ms > T_ASYM_FAST - 24'h000001);
		ext_live[mfac_pkg::EXT_ASYM] = asym33;
		ext_set[mfac_pkg::EXT_BLOCK] = blk_ms > T_BLOCK;
		ext_live[mfac_pkg::EXT_BLOCK] = sat;
		ext_set[mfac_pkg::EXT_OVL] = ovl_ms >= T_OVL;
		ext_live[mfac_pkg::EXT_OVL] = cool_ms < T_COOL;
		ext_set[mfac_pkg::EXT_REMOTE] = rem_db && rem_ms >= T_REMOTE;
		ext_live[mfac_pkg::EXT_REMOTE] = rem_db;
		ext_clr = ack_evt ? ~ext_live : '0;
		if (sync2[2] && cool_ms >= T_COOL)
			ext_clr[mfac_pkg::EXT_OVL] = 1'b1;
	end

	// Fault latches; a new event wins over a clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_lat <= '0;
			int_lat <= 1'b0;
		end else begin
			ext_lat <= (ext_lat & ~ext_clr) | ext_set;
			if (int_fault)
				int_lat <= 1'b1;
		end
	end

	// Operating mode sequence.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= mfac_pkg::ST_LAMPTEST;
			lt_ms <= 24'h000000;
			param_ms <= 24'h000000;
			show_ms <= 24'h000000;
			param_armed <= 1'b0;
			step_stored <= mfac_pkg::STEP_RST;
			nv_we <= 1'b0;
			nv_data <= mfac_pkg::STEP_RST;
		end else begin
			nv_we <= 1'b0;
			case (st)
				mfac_pkg::ST_LAMPTEST: begin
					if (tick)
						lt_ms <= lt_ms + 24'h000001;
					if (lt_ms >= T_LAMPTEST)
						st <= mfac_pkg::ST_RUN;
				end
				mfac_pkg::ST_RUN: begin
					if (btn_db && press_ms > T_PARAM && !fault_any) begin
						st <= mfac_pkg::ST_PARAM;
						param_ms <= 24'h000000;
						param_armed <= 1'b0;
					end else if (btn_rel && press_ms >= T_PRESS &&
						press_ms <= T_PARAM && !drv && !fault_any) begin
						st <= mfac_pkg::ST_SHOW;
						show_ms <= 24'h000000;
					end
				end
				mfac_pkg::ST_PARAM: begin
					if (tick)
						param_ms <= (param_ms >= T_BLANK_PER - 24'h000001) ?
							24'h000000 : param_ms + 24'h000001;
					if (btn_rel && !param_armed)
						param_armed <= 1'b1;
					else if (btn_rel) begin
						step_stored <= pot_pos[7:4];
						nv_data <= pot_pos[7:4];
						nv_we <= 1'b1;
						st <= mfac_pkg::ST_RUN;
					end
				end
				mfac_pkg::ST_SHOW: begin
					if (tick)
						show_ms <= show_ms + 24'h000001;
					if (show_ms >= T_SHOW)
						st <= mfac_pkg::ST_RUN;
				end
				default: st <= mfac_pkg::ST_RUN;
			endcase
		end
	end

	// Lamp pattern for the present mode.
	always_comb begin
		next_lamps = '0;
		case (st)
			mfac_pkg::ST_LAMPTEST: next_lamps = '1;
			mfac_pkg::ST_PARAM: begin
				if (param_ms >= T_BLANK)
					next_lamps = mfac_pkg::mfac_lamps_t'(pot_pos[7:4]);
			end
			mfac_pkg::ST_SHOW:
				next_lamps = mfac_pkg::mfac_lamps_t'(step_stored);
			default: begin
				next_lamps.power = (msg_cond && !fault_any) ? blink : 1'b1;
				next_lamps.fault = int_lat || ((|ext_lat) && blink);
				next_lamps.ccw = drive_ccw;
				next_lamps.cw = sync2[3];
			end
		endcase
	end

	// Power path, relay and lamps.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_en <= 1'b0;
			check_relay <= 1'b0;
			lamps <= '0;
		end else begin
			motor_en <= drv && !fault_any && st != mfac_pkg::ST_LAMPTEST &&
				st != mfac_pkg::ST_PARAM;
			check_relay <= fault_any || msg_cond;
			lamps <= next_lamps;
		end
	end

	// APB slave: data latched in setup, answered in the access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= mfac_pkg::CTRL_RST;
			sw_ack <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			sw_ack <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h00000000;
				pslverr <= 1'b0;
				if (paddr == mfac_pkg::OFS_CTRL) begin
					if (!pwrite)
						prdata <= {30'h00000000, ctrl};
				end else if (paddr == mfac_pkg::OFS_STATUS) begin
					if (!pwrite)
						prdata <= {21'h000000, 1'(st), st == mfac_pkg::ST_PARAM,
							int_lat, ext_lat, msg_cond, check_relay, motor_en};
				end else if (paddr == mfac_pkg::OFS_STEP) begin
					if (!pwrite)
						prdata <= {24'h000000, pot_pos[7:4], step_stored};
				end else
					pslverr <= 1'b1;
			end
			if (psel && penable && pwrite && paddr == mfac_pkg::OFS_CTRL) begin
				ctrl <= pwdata[1:0];
				sw_ack <= pwdata[mfac_pkg::CTRL_ACK_BIT];
			end
		end
	end

	sequence s_motor_off;
		!motor_en [*2];
	endsequence

	sequence s_param_blank;
		lamps == '0 ##1 lamps == '0;
	endsequence

	AST_FAULT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		fault_any |=> !motor_en) else $error("Motor on during fault.");
	AST_FAULT_LAMP: assert property (@(posedge pclk) disable iff (!presetn)
		int_lat && st == mfac_pkg::ST_RUN |=> lamps.fault)
		else $error("Fault lamp dark on internal error.");
	AST_INT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		int_lat |=> int_lat ##0 s_motor_off) else $error("Internal error lost.");
	AST_MSG_RUN: assert property (@(posedge pclk) disable iff (!presetn)
		drv && !fault_any && st == mfac_pkg::ST_RUN |=> motor_en)
		else $error("Power path cut without fault.");
	AST_FAST_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
		fast_ms == T_ASYM_FAST && !int_lat |=> ext_lat[mfac_pkg::EXT_ASYM]
		##1 !motor_en) else $error("Strong asymmetry not tripped.");
	AST_REMOTE_STUCK: assert property (@(posedge pclk)
		disable iff (!presetn) rem_db && rem_ms == T_REMOTE |=>
		ext_lat[mfac_pkg::EXT_REMOTE])
		else $error("Stuck remote input not flagged.");
	AST_RELAY: assert property (@(posedge pclk) disable iff (!presetn)
		(fault_any || msg_cond) |=> check_relay) else $error("Relay idle.");
	AST_PARAM_ENTRY: assert property (@(posedge pclk)
		disable iff (!presetn) $rose(st == mfac_pkg::ST_PARAM) |=>
		s_param_blank) else $error("No lamp flash on entry.");
	AST_NV_COMMIT: assert property (@(posedge pclk)
		disable iff (!presetn) nv_we |-> $past(st) == mfac_pkg::ST_PARAM &&
		nv_data == step_stored ##1 !nv_we) else $error("Bad commit.");

endmodule // mfac_top

// File: mfac_top_test.sv
// Self-checking testbench of the motor fault acknowledge controller.
module mfac_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS = 4;
	localparam int PRESS = 20;
	localparam int PARAM = 60;
	localparam int FAST = 20;
	localparam int SLOW = 100;
	localparam int BLK = 20;
	localparam int COOL = 30;
	localparam int OVL = 40;
	localparam int SHOW = 30;
	localparam int REM = 20;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, rerr, btn_front, remote_ack, auto_strap = 1'b0;
	logic dir_cw = 1'b0, dir_ccw = 1'b0, ext_fault = 1'b0, int_fault = 1'b0;
	logic msg_cond = 1'b0, motor_en, check_relay, nv_we, hit, off;
	logic [15:0] i_l1, i_l3;
	logic [7:0] pot_pos = 8'hA5;
	logic [3:0] nv_data;
	logic [13:0] pins;
	mfac_pkg::mfac_lamps_t lamps;
	int n_errors = 0;
	int samples_checked = 0;
	assign pins = {auto_strap, dir_cw, dir_ccw, ext_fault, int_fault, msg_cond,
		pot_pos};

	mfac_top #(.TICK_CYC(MS), .T_PRESS(24'(PRESS)), .T_PARAM(24'(PARAM)),
		.T_SHOW(24'(SHOW)), .T_BLANK(24'h3), .T_BLANK_PER(24'h14),
		.T_ASYM_SLOW(24'(SLOW)), .T_ASYM_FAST(24'(FAST)), .T_REMOTE(24'(REM)),
		.T_BLOCK(24'(BLK)), .T_COOL(24'(COOL)), .T_OVL(24'(OVL)),
		.T_LAMPTEST(24'hA), .T_DEBOUNCE(24'h2), .T_FLASH(24'h5)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .btn_front(btn_front),
		.remote_ack(remote_ack), .auto_strap(pins[13]), .dir_cw(pins[12]),
		.dir_ccw(pins[11]), .ext_fault(pins[10]), .i_l1(i_l1), .i_l3(i_l3),
		.pot_pos(pins[7:0]), .int_fault(pins[9]), .msg_cond(pins[8]),
		.motor_en(motor_en), .check_relay(check_relay), .lamps(lamps),
		.nv_we(nv_we), .nv_data(nv_data));
	mfac_plant plant (.pclk(pclk), .motor_en(motor_en),
		.btn_front(btn_front), .remote_ack(remote_ack), .i_l1(i_l1),
		.i_l3(i_l3));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic wait_ms(input int ms);
		repeat (ms * MS) @(posedge pclk);
	endtask
	task automatic wait_en(input logic v, input int ms);
		for (int k = 0; k < ms * MS && motor_en !== v; k++)
			@(posedge pclk);
		chk(motor_en, v);
	endtask
	task automatic watch(input logic [3:0] m, input logic [3:0] v, input int ms);
		hit = 1'b0;
		off = 1'b0;
		repeat (ms * MS) begin
			@(posedge pclk);
			if ((lamps & m) === v) hit = 1'b1;
			if ((lamps & m) === 4'h0) off = 1'b1;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
		chk(rerr, ee);
	endtask
	task automatic curr(input logic [15:0] a, input logic [15:0] b);
		plant.set_l1 <= a;
		plant.set_l3 <= b;
	endtask
	task automatic recover;
		curr(16'h0, 16'h0);
		plant.press(5);
		wait_en(1'b1, 5);
	endtask
	task automatic ext_trip;
		ext_fault <= 1'b1;
		wait_en(1'b0, 5);
		ext_fault <= 1'b0;
	endtask

	initial begin
		{presetn, psel, penable, pwrite} <= 4'h0;
		paddr <= 12'h000;
		pwdata <= 32'h00000000;
		repeat (2) @(posedge pclk);
		chk(32'({motor_en, check_relay, lamps, pready, nv_we}), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(lamps, 4'hF);
		rdc(mfac_pkg::OFS_CTRL, 32'h2, 1'b0);
		rdc(mfac_pkg::OFS_STEP, 32'hA0, 1'b0);
		rdc(12'hFFC, 32'h0, 1'b1);
		apb(1'b1, 12'hFFC, 32'h1);
		wait_ms(12);
		note("reset");
		dir_ccw <= 1'b1;
		wait_en(1'b1, 5);
		chk(lamps, 4'hA);
		chk(check_relay, 1'b0);
		dir_ccw <= 1'b0;
		dir_cw <= 1'b1;
		wait_ms(5);
		ext_fault <= 1'b1;
		wait_en(1'b0, 5);
		chk(check_relay, 1'b1);
		watch(4'h4, 4'h4, 15);
		chk(32'({hit, off}), 32'h3);
		plant.press(5);
		chk(motor_en, 1'b0);
		ext_fault <= 1'b0;
		plant.press(1);
		chk(motor_en, 1'b0);
		plant.press(5);
		wait_en(1'b1, 5);
		ext_trip();
		plant.press(PRESS + 10);
		chk(motor_en, 1'b0);
		apb(1'b1, mfac_pkg::OFS_CTRL, 32'h3);
		wait_en(1'b1, 5);
		note("acknowledge");
		ext_trip();
		plant.remote(5);
		wait_en(1'b1, 5);
		plant.remote(REM + 10);
		chk(motor_en, 1'b0);
		rdc(mfac_pkg::OFS_STATUS, 32'h482, 1'b0);
		apb(1'b1, mfac_pkg::OFS_CTRL, 32'h0);
		plant.remote(5);
		chk(motor_en, 1'b0);
		apb(1'b1, mfac_pkg::OFS_CTRL, 32'h2);
		recover();
		note("remote");
		msg_cond <= 1'b1;
		watch(4'h8, 4'h8, 15);
		chk(32'({hit, off, motor_en}), 32'h7);
		chk(check_relay, 1'b1);
		msg_cond <= 1'b0;
		note("message");
		curr(16'h46, 16'hA);
		wait_en(1'b0, FAST + 2);
		recover();
		curr(16'h3C, 16'h1E);
		wait_ms(FAST + 5);
		chk(motor_en, 1'b1);
		wait_en(1'b0, SLOW);
		recover();
		curr(16'hFFFF, 16'hFFFF);
		wait_ms(BLK / 2);
		chk(motor_en, 1'b1);
		wait_en(1'b0, BLK);
		recover();
		note("current");
		auto_strap <= 1'b1;
		curr(16'h64, 16'h64);
		wait_en(1'b0, OVL + 5);
		curr(16'h0, 16'h0);
		wait_ms(COOL / 2);
		chk(motor_en, 1'b0);
		wait_en(1'b1, COOL);
		auto_strap <= 1'b0;
		dir_cw <= 1'b0;
		wait_ms(5);
		plant.press(PRESS + 10);
		chk(lamps, 4'h0);
		wait_ms(SHOW);
		chk(lamps, 4'h8);
		note("auto and show");
		dir_cw <= 1'b1;
		wait_en(1'b1, 5);
		int_fault <= 1'b1;
		@(posedge pclk);
		int_fault <= 1'b0;
		wait_en(1'b0, 5);
		plant.press(5);
		apb(1'b1, mfac_pkg::OFS_CTRL, 32'h3);
		wait_ms(5);
		chk(motor_en, 1'b0);
		watch(4'h4, 4'h4, 15);
		chk(off, 1'b0);
		note("internal");
		presetn <= 1'b0;
		dir_cw <= 1'b0;
		pot_pos <= 8'h7C;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_ms(12);
		fork
			plant.press(PARAM + 10);
		join_none
		wait_ms(PARAM + 4);
		watch(4'hF, 4'h7, 24);
		chk(hit, 1'b1);
		chk(off, 1'b1);
		fork
			plant.press(5);
		join_none
		for (int k = 0; k < 20 * MS && nv_we !== 1'b1; k++)
			@(posedge pclk);
		chk(nv_we, 1'b1);
		chk(nv_data, 4'h7);
		wait_ms(10);
		rdc(mfac_pkg::OFS_STEP, 32'h77, 1'b0);
		note("parameter");
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		end_sim();
	end
endmodule // mfac_top_test
